// *** hw/bmsa_arbiter.sv ***
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module bmsa_arbiter
  import bmsa_pkg::*;
#(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [N-1:0] m_req,
  input wire logic [2*N-1:0] m_qos,
  input wire logic acc_done,
  input wire logic acc_nonseq,
  input wire logic acc_incr,
  output logic [N-1:0] grant,
  output logic grant_valid,
  output logic burst_end
);
  localparam int IW = $clog2(N);

  logic wait_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic wr_ack;
  logic [2:0] ubt_q [N];
  logic qsel_q [N];
  logic [1:0] pool_q [N];
  logic [SLOT_W-1:0] slot_q;
  logic [SLOT_W-1:0] cnt_q;
  logic [BEAT_W-1:0] beat_q;
  logic [BEAT_W-1:0] beat_idx;
  bmsa_state_t state_q;
  logic [IW-1:0] owner_q;
  logic [N-1:0] grant_q;
  logic gv_q;
  logic end_q;
  logic [2:0] ubt_own;
  logic own_req;
  logic hit;
  logic slot_exp;
  logic arb_pt;

  bmsa_pick_if #(.N(N)) pif ();

  bmsa_pick #(.N(N)) u_pick (
    .pif(pif)
  );

  // Bus handshake: one wait cycle, then a single low cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign wr_ack = avs_write && !wait_q;

  // Read data captured while the request waits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= '0;
    end else if (avs_read && wait_q) begin
      rd_q <= rd_d;
    end
  end

  // Readback mux; unmapped addresses read zero
  always_comb begin
    rd_d = '0;
    for (int i = 0; i < N; i++) begin
      if (avs_address == OFF_MCFG0 + 8'(i) * MCFG_STRIDE) begin
        rd_d[2:0] = ubt_q[i];
        rd_d[MCFG_QSEL_BIT] = qsel_q[i];
      end
      if (avs_address == ((i < 8) ? OFF_PRAS : OFF_PRBS)) begin
        rd_d[PR_STRIDE*(i%8)+:2] = pool_q[i];
      end
    end
    if (avs_address == OFF_SCFG) begin
      rd_d[SLOT_W-1:0] = slot_q;
    end
    if (avs_address == OFF_STAT) begin
      rd_d[0] = gv_q;
      rd_d[STAT_OWN_LSB+:IW] = owner_q;
      rd_d[STAT_CNT_LSB+:SLOT_W] = cnt_q;
    end
  end

  // Per-master configuration and pool selection
  for (genvar g = 0; g < N; g++) begin : g_mst
    localparam logic [7:0] PR_OFF = (g < 8) ? OFF_PRAS : OFF_PRBS;
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        ubt_q[g] <= UBT_RST;
        qsel_q[g] <= 1'b0;
        pool_q[g] <= POOL_RST;
      end else if (wr_ack) begin
        if (avs_address == OFF_MCFG0 + 8'(g) * MCFG_STRIDE) begin
          ubt_q[g] <= avs_writedata[2:0];
          qsel_q[g] <= avs_writedata[MCFG_QSEL_BIT];
        end
        if (avs_address == PR_OFF) begin
          pool_q[g] <= avs_writedata[PR_STRIDE*(g%8)+:2];
        end
      end
    end
    // QoS input or software field decides the pool
    assign pif.pool[2*g+:2] = qsel_q[g] ? m_qos[2*g+:2] : pool_q[g];
  end

  // Slot quantum register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slot_q <= SLOT_RST;
    end else if (wr_ack && avs_address == OFF_SCFG) begin
      slot_q <= avs_writedata[SLOT_W-1:0];
    end
  end

  assign pif.req = m_req;
  assign pif.last = owner_q;

  // Burst beat position and forced end
  assign ubt_own = ubt_q[owner_q];
  assign own_req = m_req[owner_q];
  assign beat_idx = acc_nonseq ? '0 : beat_q;
  assign hit = (state_q == BMSA_OWNED) && acc_done && acc_incr &&
               (ubt_own != UBT_INF) &&
               (beat_idx == UBT_LAST[ubt_own]);
  assign slot_exp = (slot_q != '0) && (cnt_q == '0);

  // Arbitration points: idle, released, or an access boundary that ends a burst or an expired slot
  always_comb begin
    case (state_q)
      BMSA_IDLE: arb_pt = 1'b1;
      BMSA_OWNED: arb_pt = !own_req ||
                           (acc_done && (hit || slot_exp));
      default: arb_pt = 1'b1;
    endcase
  end

  // Grant state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= BMSA_IDLE;
      owner_q <= '0;
      grant_q <= '0;
      gv_q <= 1'b0;
    end else if (arb_pt) begin
      if (pif.found) begin
        state_q <= BMSA_OWNED;
        owner_q <= pif.win;
        grant_q <= N'(1) << pif.win;
        gv_q <= 1'b1;
      end else begin
        state_q <= BMSA_IDLE;
        grant_q <= '0;
        gv_q <= 1'b0;
      end
    end
  end

  // Slot cycle counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (arb_pt && pif.found) begin
      cnt_q <= slot_q;
    end else if (state_q == BMSA_OWNED && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Beat counter inside an undefined-length burst
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      beat_q <= '0;
      end_q <= 1'b0;
    end else begin
      end_q <= hit;
      if (arb_pt || (acc_done && !acc_incr)) begin
        beat_q <= '0;
      end else if (state_q == BMSA_OWNED && acc_done) begin
        beat_q <= hit ? '0 : beat_idx + 1'b1;
      end
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rd_q;
  assign grant = grant_q;
  assign grant_valid = gv_q;
  assign burst_end = end_q;

  // Helpers watched only by the checks below
  logic [1:0] win_pool;
  logic [1:0] max_pool;
  logic rivals;
  logic lower_rival;
  always_comb begin
    win_pool = pif.pool[2*pif.win+:2];
    max_pool = '0;
    rivals = 1'b0;
    lower_rival = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (m_req[i] && pif.pool[2*i+:2] > max_pool) begin
        max_pool = pif.pool[2*i+:2];
      end
      if (m_req[i] && pif.pool[2*i+:2] == win_pool &&
          IW'(i) != owner_q) begin
        rivals = 1'b1;
      end
      if (m_req[i] && pif.pool[2*i+:2] == win_pool &&
          IW'(i) < pif.win) begin
        lower_rival = 1'b1; // Lower index would win a fixed pool
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_arb;
    arb_pt && pif.found;
  endsequence

  sequence s_last128;
    state_q == BMSA_OWNED && acc_done && acc_incr &&
    ubt_own == UBT_128 && beat_idx == 8'h7F;
  endsequence

  sequence s_expire;
    state_q == BMSA_OWNED && own_req && acc_done &&
    slot_q != '0 && cnt_q == '0;
  endsequence

  // Checks on bursts and the register bus
  AST_BURST128: assert property (s_last128 |=> burst_end)
    else $error("128-beat boundary did not end burst");
  AST_NO_END_INF: assert property (
    state_q == BMSA_OWNED && ubt_own == UBT_INF |=> !burst_end)
    else $error("unlimited burst was cut");
  AST_UBT_WR: assert property (
    wr_ack && avs_address == OFF_MCFG0 |=>
    ubt_q[0] == $past(avs_writedata[2:0]))
    else $error("burst type field not written");
  AST_BUS_ANSWER: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  AST_BUS_ONE: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // Checks on the slot counter and on holding the grant
  AST_SLOT_LOAD: assert property (
    s_arb |=> cnt_q == $past(slot_q))
    else $error("slot counter not loaded at arbitration");
  AST_SLOT_DEC: assert property (
    state_q == BMSA_OWNED && !arb_pt && cnt_q != '0 |=>
    cnt_q == $past(cnt_q) - 1'b1)
    else $error("slot counter did not count down");
  AST_SLOT_REARB: assert property (
    s_expire |=> cnt_q == $past(slot_q) && gv_q)
    else $error("expired slot did not rearbitrate");
  AST_SLOT_OFF: assert property (
    state_q == BMSA_OWNED && own_req && slot_q == '0 && !hit |=>
    $stable(grant) && grant_valid)
    else $error("disabled slot limit broke an access");
  AST_NO_PREEMPT: assert property (
    state_q == BMSA_OWNED && own_req && !acc_done |=>
    gv_q && $stable(owner_q))
    else $error("grant moved during an access");
  // Checks on pools and the shape of the grant
  AST_POOL_FIRST: assert property (
    s_arb |-> win_pool == max_pool ##1 gv_q)
    else $error("lower pool won over higher pool");
  AST_FIXED_ORDER: assert property (
    s_arb ##0 (win_pool == 2'h2 || win_pool == 2'h1) |-> !lower_rival)
    else $error("fixed pool skipped a lower index");
  AST_GRANT_SHAPE: assert property (
    gv_q |-> grant_q == N'(1) << owner_q)
    else $error("grant does not match owner");
  AST_GRANT_IDLE: assert property (
    !gv_q |-> grant_q == '0)
    else $error("grant shown while no owner");
  AST_ROTATE: assert property (
    state_q == BMSA_OWNED ##0 s_arb ##0
    (win_pool == POOL_CRIT || win_pool == POOL_BG) && rivals
    |-> pif.win != owner_q)
    else $error("round-robin pool regranted last master");
  AST_RESET_POOL: assert property (
    $rose(resetn) |-> pool_q[0] == POOL_RST [*2])
    else $error("pool field not zero after reset");
endmodule
`default_nettype wire

// *** hw/bmsa_pkg.sv ***
package bmsa_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MCFG0 = 8'h00;
  localparam logic [7:0] OFF_SCFG = 8'h40;
  localparam logic [7:0] OFF_PRAS = 8'h44;
  localparam logic [7:0] OFF_PRBS = 8'h48;
  localparam logic [7:0] OFF_STAT = 8'h4C;
  localparam logic [7:0] MCFG_STRIDE = 8'h04;
  // Field positions
  localparam int MCFG_QSEL_BIT = 4;
  localparam int PR_STRIDE = 4;
  localparam int STAT_OWN_LSB = 8;
  localparam int STAT_CNT_LSB = 16;
  localparam int SLOT_W = 8;
  localparam int BEAT_W = 8;
  // Values after reset
  localparam logic [2:0] UBT_RST = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_RST = 8'hFF;
  localparam logic [1:0] POOL_RST = 2'h0;
  // Undefined-length burst codes and index of their last beat
  localparam logic [2:0] UBT_INF = 3'h0;
  localparam logic [2:0] UBT_128 = 3'h7;
  localparam logic [BEAT_W-1:0] UBT_LAST [8] = '{
    8'h00, 8'h00, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h7F};
  // Pools that rotate
  localparam logic [1:0] POOL_CRIT = 2'h3;
  localparam logic [1:0] POOL_BG = 2'h0;
  typedef enum logic [1:0] {
    BMSA_IDLE = 2'b01,
    BMSA_OWNED = 2'b10
  } bmsa_state_t;
endpackage

// *** hw/bmsa_pick_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface bmsa_pick_if #(parameter int N = 4);
  localparam int IW = $clog2(N);
  logic [N-1:0] req;
  logic [2*N-1:0] pool;
  logic [IW-1:0] last;
  logic [IW-1:0] win;
  logic found;
  modport arb (output req, output pool, output last,
               input win, input found);
  modport pick (input req, input pool, input last,
                output win, output found);
endinterface
`default_nettype wire

// *** hw/bmsa_pick.sv ***
`timescale 1ns/1ns
`default_nettype none
module bmsa_pick
  import bmsa_pkg::*;
#(
  parameter int N = 4
) (
  bmsa_pick_if.pick pif
);
  localparam int IW = $clog2(N);

  // Highest pool first, then rotating or fixed order inside it
  always_comb begin
    logic [IW-1:0] j;
    logic hit;
    hit = 1'b0;
    j = '0;
    pif.win = '0;
    for (int lv = 3; lv >= 0; lv--) begin
      for (int o = 0; o < N; o++) begin
        if (2'(lv) == POOL_CRIT || 2'(lv) == POOL_BG) begin
          j = IW'((int'(pif.last) + 1 + o) % N);
        end else begin
          j = IW'(o);
        end
        if (!hit && pif.req[j] && pif.pool[2*j+:2] == 2'(lv)) begin
          hit = 1'b1;
          pif.win = j;
        end
      end
    end
    pif.found = hit;
  end
endmodule
`default_nettype wire

// *** test/bmsa_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module bmsa_master_model #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [N-1:0] want,
  input wire logic [N-1:0] grant,
  input wire logic stall,
  output logic [N-1:0] m_req,
  output logic acc_done,
  output logic acc_nonseq,
  output logic acc_incr
);
  logic [N-1:0] grant_q;

  // Requests follow the wish list; INCR beats run while granted
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m_req <= '0;
      grant_q <= '0;
      acc_done <= 1'b0;
      acc_nonseq <= 1'b0;
      acc_incr <= 1'b0;
    end else begin
      m_req <= want;
      grant_q <= grant;
      acc_done <= |grant && !stall; // Stall holds the access open
      acc_nonseq <= |grant && grant != grant_q;
      acc_incr <= |grant;
    end
  end
endmodule
`default_nettype wire

// *** test/test_bus_matrix_slave_arbiter.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_bus_matrix_slave_arbiter;
  import bmsa_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] m_req, grant;
  logic [3:0] want = 4'h0;
  logic [7:0] m_qos = 8'h00;
  logic stall = 1'b0;
  logic acc_done, acc_nonseq, acc_incr, grant_valid, burst_end;
  logic [31:0] rd_q;
  int bad_count = 0;
  int check_count = 0;

  // Clock, 100 ns period
  always #50 clk = ~clk;

  bmsa_arbiter #(.N(4)) i_dut (.clk(clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .m_req(m_req), .m_qos(m_qos), .acc_done(acc_done),
    .acc_nonseq(acc_nonseq), .acc_incr(acc_incr), .grant(grant),
    .grant_valid(grant_valid), .burst_end(burst_end));

  bmsa_master_model #(.N(4)) i_master (.clk(clk), .resetn(resetn),
    .want(want), .grant(grant), .stall(stall), .m_req(m_req),
    .acc_done(acc_done), .acc_nonseq(acc_nonseq), .acc_incr(acc_incr));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic next_grant(output logic [3:0] g, output int cyc);
    logic [3:0] old;
    old = grant;
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
    end while (grant === old || grant === 4'h0);
    g = grant;
  endtask

  task automatic t_regs;
    logic [7:0] a [6] = '{OFF_MCFG0, OFF_SCFG, OFF_PRAS, OFF_PRBS,
                          OFF_STAT, 8'h80};
    logic [31:0] e [6] = '{32'h0, {24'h0, SLOT_RST}, 32'h0, 32'h0,
                           32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, a[i], 32'h0);
      chk("reset value", e[i], rd_q);
    end
    bus(1'b1, 8'h80, '1);
    bus(1'b0, 8'h80, 32'h0);
    chk("unmapped", 32'h0, rd_q);
    bus(1'b1, OFF_STAT, '1);
    bus(1'b0, OFF_STAT, 32'h0);
    chk("status read only", 32'h0, rd_q);
    bus(1'b1, OFF_MCFG0, '1);
    bus(1'b0, OFF_MCFG0, 32'h0);
    chk("master config", 32'h17, rd_q);
    bus(1'b1, OFF_MCFG0, 32'h0);
  endtask

  task automatic t_rotate;
    logic [3:0] g;
    int cyc;
    bus(1'b1, OFF_SCFG, 32'h2);
    want <= 4'h1;
    next_grant(g, cyc);
    chk("first grant", 32'h1, g);
    want <= 4'hF;
    for (int i = 1; i < 5; i++) begin
      next_grant(g, cyc);
      chk("rotation", 4'h1 << (i % 4), g);
      chk("slot length", 1, cyc >= 2 || i == 1);
    end
    want <= 4'h0;
    repeat (4) @(posedge clk);
    chk("released valid", 32'h0, grant_valid);
  endtask

  task automatic t_pools;
    logic [3:0] g, p;
    int cyc;
    bus(1'b1, OFF_PRAS, 32'h320);
    bus(1'b1, OFF_MCFG0 + 3 * MCFG_STRIDE, 32'h10);
    m_qos <= 8'hC0;
    want <= 4'hF;
    next_grant(p, cyc);
    for (int i = 0; i < 4; i++) begin
      next_grant(g, cyc);
      chk("top pool", 1, (g == 4'h4 || g == 4'h8) && g != p);
      p = g;
    end
    want <= 4'h3;
    next_grant(g, cyc);
    chk("fixed pool", 32'h2, g);
    repeat (10) @(posedge clk);
    chk("fixed hold", 32'h2, grant);
    want <= 4'h0;
    m_qos <= 8'h00;
    bus(1'b1, OFF_PRAS, 32'h0);
    bus(1'b1, OFF_MCFG0 + 3 * MCFG_STRIDE, 32'h0);
  endtask

  task automatic t_hold;
    logic [3:0] g;
    int cyc;
    stall <= 1'b1;
    want <= 4'h3;
    next_grant(g, cyc);
    repeat (20) @(posedge clk);
    chk("stalled hold", g, grant);
    chk("stalled valid", 32'h1, grant_valid);
    bus(1'b0, OFF_STAT, 32'h0);
    chk("status", 32'h1, rd_q);
    bus(1'b1, OFF_SCFG, 32'h0);
    stall <= 1'b0;
    repeat (40) @(posedge clk);
    chk("no limit hold", g, grant);
    want <= 4'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_burst;
    int n;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, OFF_MCFG0, c);
      want <= 4'h1;
      n = 0;
      do begin
        @(posedge clk);
        if (acc_done === 1'b1 && burst_end !== 1'b1) n++;
      end while (burst_end !== 1'b1 && n < 300);
      chk("burst beats", c == 0 ? 300 : (c == 1 ? 1 : 1 << c), n);
      want <= 4'h0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_rotate;
    t_pools;
    t_hold;
    t_burst;
    final_report;
  end

  // Watchdog, well above the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report;
  end
endmodule
`default_nettype wire
